// file: hdl/phbr_pkg.sv
/*
 * Shared types and constants for the host bridge logic.
 * Assumes one system clock and an active-high asynchronous reset.
 */
// Function
// [R01] Device-type outbound accesses forwarded as memory
// [R02] Non-cacheable outbound accesses accepted and forwarded
// [R03] Unaligned normal accesses become byte-enabled requests
// [R04] Non-prefetchable BARs reachable with 32-bit addresses
// [R05] Fixed-offset window above 4G, firmware programmed
// [R06] System should prefer one-to-one mapping below 4GB
// [R07] Inbound addresses pass unmodified
// [R08] No remapping without translation unit
// [R09] MSI writes pass as posted writes
// [R10] Each MSI reaches controller with own identifier
// [R11] INTx messages become shared interrupt lines
// [R12] Each INTx line has distinct interrupt output
// [R13] Software sets legacy interrupts level-sensitive
// [R14] Legacy delivery uses no private registers
// [R15] Assignable functions implement function level reset
// [R16] Coherent path shares processors' inner domain
// [R17] No merging before final attributes known
// [R18] Mode ignoring ATS memory attributes
// [R19] Inbound default normal write-back outer shareable
// [R20] TH bit set means allocate hints
// [R21] No_snoop forces normal non-cacheable (honoured ATS attributes and translation unit attributes replace it)
// [R22] Non-cacheable always treated outer shareable (translation unit attributes are passed on without forcing outer_sh)
// [R23] Translation unit output replaces resolved attributes
// [R24] INTx output high from assert to deassert
// [R25] Window addresses get offset subtracted
package phbr_pkg;

    localparam int ADDR_W = 64;
    localparam int DATA_W = 32;
    localparam int BE_W   = DATA_W / 8;

    // Register map of the plain control port
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_WIN_BASE = 4'h1;
    localparam logic [3:0] REG_WIN_LIM  = 4'h2;
    localparam logic [3:0] REG_WIN_OFS  = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;

    localparam int CTRL_WIN_EN  = 0;
    localparam int CTRL_AMA_IGN = 1;

    localparam logic [1:0]        CTRL_RST   = 2'h3;
    localparam logic [ADDR_W-1:0] WIN_RST    = 64'h0;
    localparam logic [ADDR_W-1:0] FOUR_GIG   = 64'h0000_0001_0000_0000;

    typedef enum logic [1:0] {
        PHBR_MT_DEVICE = 2'h0,
        PHBR_MT_NORMAL_NC = 2'h1,
        PHBR_MT_NORMAL_WB = 2'h2
    } phbr_mtype_e;

    // Memory attributes carried with each inbound request
    typedef struct packed {
        phbr_mtype_e mtype;
        logic        outer_sh;
        logic        rd_alloc;
        logic        wr_alloc;
    } phbr_attr_s;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0]   be;
    } phbr_req_s;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              translated;
        logic              no_snoop;
        logic              th;
        logic              msi;
        logic              ama_valid;
        phbr_attr_s        ama;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0]   be;
    } phbr_in_req_s;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              posted;
        phbr_attr_s        attr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0]   be;
    } phbr_in_out_s;

    typedef struct packed {
        logic             valid;
        logic             assert_n_deassert;
        logic [1:0]       line;
    } phbr_intx_s;

    localparam int INTX_LINES = 4;

endpackage

// file: hdl/phbr_bridge.sv
/*
 * Host bridge datapath: outbound address window and byte enables,
 * inbound attribute resolution, legacy interrupt levels, control port.
 * Assumes the root port and translation unit never stall this block.
 */
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module phbr_bridge #(
    parameter int NLINES = phbr_pkg::INTX_LINES
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [3:0]                 reg_addr,
    input  wire logic [63:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [63:0]                     reg_rdata,
    input  wire phbr_pkg::phbr_req_s        cpu_req,
    input  wire phbr_pkg::phbr_mtype_e      cpu_mtype,
    input  wire logic [1:0]                 cpu_unalign,
    output phbr_pkg::phbr_req_s             pcie_req,
    input  wire phbr_pkg::phbr_in_req_s     ep_req,
    output phbr_pkg::phbr_in_out_s          smmu_req,
    input  wire logic                       smmu_present,
    input  wire phbr_pkg::phbr_attr_s       smmu_attr,
    input  wire logic                       smmu_attr_valid,
    output phbr_pkg::phbr_in_out_s          sys_req,
    input  wire phbr_pkg::phbr_intx_s       intx_msg,
    output logic [NLINES-1:0]               intx_irq
);

    typedef struct packed {
        logic [1:0]                      ctrl;
        logic [phbr_pkg::ADDR_W-1:0]     win_base;
        logic [phbr_pkg::ADDR_W-1:0]     win_lim;
        logic [phbr_pkg::ADDR_W-1:0]     win_ofs;
        logic [63:0]                     rdata;
        phbr_pkg::phbr_req_s             pcie;
        phbr_pkg::phbr_in_out_s          smmu;
        phbr_pkg::phbr_in_out_s          sys;
        logic [NLINES-1:0]               irq;
        logic [15:0]                     outb_cnt;
    } phbr_state_s;

    phbr_state_s st_q;
    phbr_state_s st_d;

    // Initial attributes, then No_snoop, then optional ATS attributes
    function automatic phbr_pkg::phbr_attr_s resolve(input phbr_pkg::phbr_in_req_s r,
                                                     input logic ama_ign);
        phbr_pkg::phbr_attr_s a;
        a.mtype    = phbr_pkg::PHBR_MT_NORMAL_WB; // [R19]
        a.outer_sh = 1'b1;                        // [R19]
        a.rd_alloc = r.th & ~r.write;             // [R20]
        a.wr_alloc = r.th & r.write;              // [R20]
        if (r.no_snoop) begin
            a.mtype    = phbr_pkg::PHBR_MT_NORMAL_NC; // [R21]
            a.rd_alloc = 1'b0;
            a.wr_alloc = 1'b0;
        end
        if (r.translated && r.ama_valid && !ama_ign) begin
            a = r.ama; // [R18]
        end
        if (r.msi) begin
            // Interrupt writes must not allocate in caches
            a.mtype    = phbr_pkg::PHBR_MT_NORMAL_NC;
            a.rd_alloc = 1'b0;
            a.wr_alloc = 1'b0;
        end
        if (a.mtype != phbr_pkg::PHBR_MT_NORMAL_WB) begin
            a.outer_sh = 1'b1; // [R22]
        end
        return a;
    endfunction

    // Byte enables for a word access shifted by the low address bits
    function automatic logic [phbr_pkg::BE_W-1:0] shift_be(input logic [phbr_pkg::BE_W-1:0] be,
                                                        input logic [1:0] ofs);
        return phbr_pkg::BE_W'(be << ofs);
    endfunction

    logic in_win;
    assign in_win = st_q.ctrl[phbr_pkg::CTRL_WIN_EN]
                    && cpu_req.addr >= st_q.win_base
                    && cpu_req.addr <= st_q.win_lim;

    always_comb begin
        phbr_pkg::phbr_attr_s ra;
        ra = resolve(ep_req, st_q.ctrl[phbr_pkg::CTRL_AMA_IGN]);
        st_d       = st_q;
        st_d.rdata = 64'h0;

        if (reg_wr) begin
            unique case (reg_addr)
                phbr_pkg::REG_CTRL:     st_d.ctrl     = reg_wdata[1:0];
                phbr_pkg::REG_WIN_BASE: st_d.win_base = reg_wdata; // [R05]
                phbr_pkg::REG_WIN_LIM:  st_d.win_lim  = reg_wdata;
                phbr_pkg::REG_WIN_OFS:  st_d.win_ofs  = reg_wdata; // [R05]
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                phbr_pkg::REG_CTRL:     st_d.rdata = {62'h0, st_q.ctrl};
                phbr_pkg::REG_WIN_BASE: st_d.rdata = st_q.win_base;
                phbr_pkg::REG_WIN_LIM:  st_d.rdata = st_q.win_lim;
                phbr_pkg::REG_WIN_OFS:  st_d.rdata = st_q.win_ofs;
                phbr_pkg::REG_STATUS:   st_d.rdata = {44'h0, st_q.outb_cnt, {(4-NLINES){1'b0}},
                                                      st_q.irq};
                default:                st_d.rdata = 64'h0;
            endcase
        end

        // Outbound: every memory type is forwarded as a memory request
        st_d.pcie       = cpu_req; // [R01] [R02]
        st_d.pcie.be    = shift_be(cpu_req.be, cpu_unalign); // [R03]
        if (cpu_mtype == phbr_pkg::PHBR_MT_DEVICE) begin
            st_d.pcie.be = cpu_req.be; // [R01]
        end
        if (in_win) begin
            // Window lands below 4G so 32-bit BARs stay reachable
            st_d.pcie.addr = cpu_req.addr - st_q.win_ofs; // [R25] [R04]
        end
        if (cpu_req.valid) begin
            st_d.outb_cnt = st_q.outb_cnt + 16'h1;
        end

        // Inbound: address untouched, attributes final before issue
        st_d.smmu.valid = ep_req.valid & smmu_present; // [R23]
        st_d.smmu.write = ep_req.write;
        st_d.smmu.posted = ep_req.write;
        st_d.smmu.attr  = ra;
        st_d.smmu.addr  = ep_req.addr; // [R07]
        st_d.smmu.data  = ep_req.data;
        st_d.smmu.be    = ep_req.be;

        st_d.sys        = st_d.smmu; // [R08] [R16]
        st_d.sys.valid  = ep_req.valid & ~smmu_present;
        if (smmu_present) begin
            st_d.sys.valid = smmu_attr_valid & st_q.smmu.valid; // [R17]
            st_d.sys       = st_q.smmu;
            st_d.sys.valid = smmu_attr_valid & st_q.smmu.valid;
            st_d.sys.attr  = smmu_attr; // [R23]
        end
        // Every write, MSI or not, leaves as posted; MSI reads do not; one request per cycle, no merge
        st_d.sys.posted = st_d.sys.write; // [R09] [R10] [R17]

        if (intx_msg.valid && int'(intx_msg.line) < NLINES) begin
            st_d.irq[intx_msg.line] = intx_msg.assert_n_deassert; // [R11] [R12] [R24] [R14]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q          <= '0;
            st_q.ctrl     <= phbr_pkg::CTRL_RST;
            st_q.win_base <= phbr_pkg::WIN_RST;
            st_q.win_lim  <= phbr_pkg::WIN_RST;
            st_q.win_ofs  <= phbr_pkg::WIN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign pcie_req  = st_q.pcie;
    assign smmu_req  = st_q.smmu;
    assign sys_req   = st_q.sys;
    assign intx_irq  = st_q.irq;

    a_addr_pass: assert property (@(posedge clk) disable iff (rst) // [R07]
        ep_req.valid && !smmu_present |=> sys_req.valid && sys_req.addr == $past(ep_req.addr))
        else $error("inbound address changed");
    a_nosnoop_nc: assert property (@(posedge clk) disable iff (rst) // [R21]
        ep_req.valid && ep_req.no_snoop && !ep_req.msi && !smmu_present
        && (!ep_req.translated || st_q.ctrl[phbr_pkg::CTRL_AMA_IGN])
        |=> sys_req.attr.mtype == phbr_pkg::PHBR_MT_NORMAL_NC)
        else $error("no_snoop not non-cacheable");
    a_default_wb: assert property (@(posedge clk) disable iff (rst) // [R19]
        ep_req.valid && !ep_req.no_snoop && !ep_req.msi && !smmu_present
        && (!ep_req.translated || st_q.ctrl[phbr_pkg::CTRL_AMA_IGN])
        |=> sys_req.attr.mtype == phbr_pkg::PHBR_MT_NORMAL_WB && sys_req.attr.outer_sh)
        else $error("default attributes wrong");
    a_nc_outer: assert property (@(posedge clk) disable iff (rst) // [R22]
        sys_req.valid && sys_req.attr.mtype == phbr_pkg::PHBR_MT_NORMAL_NC && !smmu_present
        |-> sys_req.attr.outer_sh)
        else $error("non-cacheable not outer shareable");
    a_intx_hold: assert property (@(posedge clk) disable iff (rst) // [R24]
        intx_msg.valid && intx_msg.assert_n_deassert && intx_msg.line == 2'h0
        |=> intx_irq[0])
        else $error("intx line not raised");
    a_intx_clear: assert property (@(posedge clk) disable iff (rst) // [R24]
        intx_msg.valid && !intx_msg.assert_n_deassert && intx_msg.line == 2'h2
        |=> !intx_irq[2])
        else $error("intx line not released");
    a_msi_posted: assert property (@(posedge clk) disable iff (rst) // [R09]
        ep_req.valid && ep_req.msi && ep_req.write && !smmu_present
        |=> sys_req.posted && sys_req.attr.mtype == phbr_pkg::PHBR_MT_NORMAL_NC)
        else $error("interrupt write not posted");
    a_win_sub: assert property (@(posedge clk) disable iff (rst) // [R25]
        cpu_req.valid && in_win |=> pcie_req.addr == $past(cpu_req.addr) - $past(st_q.win_ofs))
        else $error("window offset not applied");
    a_ama_ignore: assert property (@(posedge clk) disable iff (rst) // [R18]
        ep_req.valid && st_q.ctrl[phbr_pkg::CTRL_AMA_IGN] && !ep_req.no_snoop && !ep_req.msi
        && !smmu_present |=> sys_req.attr.mtype == phbr_pkg::PHBR_MT_NORMAL_WB)
        else $error("ama not ignored");
    a_smmu_attr: assert property (@(posedge clk) disable iff (rst) // [R23]
        smmu_present && smmu_attr_valid && smmu_req.valid |=> sys_req.attr == $past(smmu_attr))
        else $error("translation attributes not used");
    c_msi: cover property (@(posedge clk) ep_req.valid && ep_req.msi);
    c_win: cover property (@(posedge clk) cpu_req.valid && in_win);
    c_intx: cover property (@(posedge clk) intx_irq[0] ##[1:20] !intx_irq[0]);

endmodule

// file: dv/phbr_smmu_model.sv
/*
 * Behavioural translation unit on the bridge's inbound side.
 * Assumes the bridge accepts an answer in the cycle it presents a request.
 */
`timescale 1ns/1ps
module phbr_smmu_model (
    input  wire logic                   clk,
    input  wire phbr_pkg::phbr_in_out_s smmu_req,
    output phbr_pkg::phbr_attr_s        smmu_attr,
    output logic                        smmu_attr_valid
);
    localparam logic [4:0] ANSWER = 5'h0c;
    logic flip_q = 1'b0;
    always @(posedge clk) begin
        flip_q <= ~flip_q;
    end
    // Outside a request the attributes churn, so a stale sample never matches
    assign smmu_attr = smmu_req.valid ? ANSWER : {~ANSWER[4:1], flip_q};
    assign smmu_attr_valid = smmu_req.valid;
endmodule

// file: dv/phbr_bridge_tb_top.sv
/*
 * Self-checking bench: registers, outbound window, inbound attributes,
 * translation path, legacy interrupt levels.
 * Assumes the package, the bridge and the translation model compile first.
 */
`timescale 1ns/1ps
module phbr_bridge_tb_top;
    logic                   clk, rst, reg_wr, reg_rd, smmu_present, smmu_attr_valid, rd_d, ama_on;
    logic [3:0]             reg_addr, intx_irq;
    logic [63:0]            reg_wdata, reg_rdata;
    logic [1:0]             cpu_unalign;
    logic [15:0]            lfsr = 16'h003b;
    phbr_pkg::phbr_req_s    cpu_req, pcie_req, p;
    phbr_pkg::phbr_mtype_e  cpu_mtype;
    phbr_pkg::phbr_in_req_s ep_req;
    phbr_pkg::phbr_in_out_s smmu_req, sys_req, e;
    phbr_pkg::phbr_attr_s   smmu_attr;
    phbr_pkg::phbr_intx_s   intx_msg;
    phbr_pkg::phbr_in_out_s sq[$];
    phbr_pkg::phbr_req_s    pq[$];
    logic [63:0]            rq[$], aq[$];
    int                     am[$], m, err_count, check_count;

    phbr_bridge #(.NLINES(4)) dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_req(cpu_req), .cpu_mtype(cpu_mtype), .cpu_unalign(cpu_unalign),
        .pcie_req(pcie_req), .ep_req(ep_req), .smmu_req(smmu_req),
        .smmu_present(smmu_present), .smmu_attr(smmu_attr),
        .smmu_attr_valid(smmu_attr_valid), .sys_req(sys_req), .intx_msg(intx_msg),
        .intx_irq(intx_irq));
    phbr_smmu_model smmu (.clk(clk), .smmu_req(smmu_req), .smmu_attr(smmu_attr),
        .smmu_attr_valid(smmu_attr_valid));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Lowers every strobe but the caller's, so one request never lingers
    task automatic drop(input int keep);
        if (keep != 0) begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
        if (keep != 1) cpu_req.valid <= 1'b0;
        if (keep != 2) ep_req.valid <= 1'b0;
        if (keep != 3) intx_msg.valid <= 1'b0;
    endtask
    task automatic idle(input int n);
        drop(-1);
        repeat (n) @(posedge clk);
    endtask
    // For a read, d is the expected data
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [63:0] d);
        drop(0);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) rq.push_back(d);
        @(posedge clk);
    endtask
    task automatic out_op(input logic [1:0] mt, input logic [1:0] u, input logic [63:0] a,
                          input logic [63:0] ea);
        phbr_pkg::phbr_req_s r, x;
        r = '{valid:1'b1, write:1'b1, addr:a, data:{rnd(), rnd()}, be:4'h1};
        x = r;
        x.addr = ea;
        x.be = (mt == 2'h0) ? r.be : r.be << u;
        drop(1);
        cpu_req <= r;
        cpu_mtype <= phbr_pkg::phbr_mtype_e'(mt);
        cpu_unalign <= u;
        pq.push_back(x);
        @(posedge clk);
    endtask
    // k: write, no-snoop, hint, message-signalled
    task automatic in_op(input logic [3:0] k);
        phbr_pkg::phbr_in_req_s r;
        phbr_pkg::phbr_in_out_s x;
        r = '0;
        r.valid = 1'b1;
        {r.msi, r.th, r.no_snoop, r.write} = k;
        r.ama_valid = 1'b1;
        r.ama = phbr_pkg::phbr_attr_s'(5'h03);
        r.addr = {rnd(), rnd(), rnd(), rnd()};
        r.translated = lfsr[3];
        r.data = {rnd(), rnd()};
        r.be = 4'hf;
        x = '0;
        x.write = k[0];
        x.posted = k[0];
        x.addr = r.addr;
        x.data = r.data;
        x.attr.mtype = (k[1] | k[3]) ? phbr_pkg::PHBR_MT_NORMAL_NC : phbr_pkg::PHBR_MT_NORMAL_WB;
        m = k[3] ? 1 : (k[1] ? 0 : (k[2] ? 2 : 1));
        if (ama_on && r.translated) begin
            // Honoured AMA (device, both allocate) beats No_snoop; MSI stays non-cacheable
            x.attr.mtype = k[3] ? phbr_pkg::PHBR_MT_NORMAL_NC : phbr_pkg::PHBR_MT_DEVICE;
            m = k[3] ? 1 : 2;
        end
        if (smmu_present) begin
            x.attr = phbr_pkg::phbr_attr_s'(5'h0c);
            m = 1;
            aq.push_back(r.addr);
        end
        drop(2);
        ep_req <= r;
        sq.push_back(x);
        am.push_back(m);
        @(posedge clk);
    endtask
    task automatic intx(input logic a, input logic [1:0] l);
        drop(3);
        intx_msg <= '{valid:1'b1, assert_n_deassert:a, line:l};
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        rd_d <= reg_rd;
        #1;
        if (rd_d === 1'b1) chk(rq.size() > 0 && reg_rdata === rq.pop_front(), "read data");
        if (pcie_req.valid === 1'b1) begin
            p = pq.pop_front();
            chk(pcie_req === p, "outbound request");
        end
        if (smmu_req.valid === 1'b1) chk(aq.size() > 0 && smmu_req.addr === aq.pop_front(),
                                         "translation input");
        if (sys_req.valid === 1'b1) begin
            chk(sq.size() > 0, "unexpected inbound");
            e = sq.pop_front();
            m = am.pop_front();
            chk(sys_req.addr === e.addr && sys_req.write === e.write && sys_req.posted === e.posted
                && (!e.write || sys_req.data === e.data), "inbound passthrough");
            chk(sys_req.attr.mtype === e.attr.mtype && sys_req.attr.outer_sh === 1'b1,
                "inbound type");
            chk(m == 0 || ((m == 1) == ({sys_req.attr.rd_alloc, sys_req.attr.wr_alloc} === 2'h0)),
                "alloc hint");
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(50 * 3000);
        err_count++;
        $display("BAD %0t timeout", $time);
        stop_test();
    end
    initial begin
        {rst, reg_wr, reg_rd, smmu_present, rd_d} = 5'h10;
        ama_on = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        cpu_req = '0;
        cpu_mtype = phbr_pkg::PHBR_MT_DEVICE;
        cpu_unalign = '0;
        ep_req = '0;
        intx_msg = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_op(1'b0, phbr_pkg::REG_CTRL, 64'h3);
        reg_op(1'b0, phbr_pkg::REG_WIN_LIM, 64'h0);
        reg_op(1'b1, 4'hf, 64'hffff_ffff_ffff_ffff);
        reg_op(1'b0, 4'hf, 64'h0);
        reg_op(1'b1, phbr_pkg::REG_WIN_BASE, 64'h0000_0008_0000_0000);
        reg_op(1'b1, phbr_pkg::REG_WIN_LIM, 64'h0000_0008_0fff_ffff);
        reg_op(1'b1, phbr_pkg::REG_WIN_OFS, 64'h0000_0007_c000_0000);
        reg_op(1'b0, phbr_pkg::REG_WIN_OFS, 64'h0000_0007_c000_0000);
        for (int i = 0; i < 3; i++) begin
            out_op(i[1:0], i[1:0] + 2'h1, 64'h0000_0008_0000_1000, 64'h0000_0000_4000_1000);
            out_op(i[1:0], 2'h3, 64'h0000_0009_0000_0000, 64'h0000_0009_0000_0000);
        end
        out_op(2'h2, 2'h2, 64'h0000_0008_0fff_fff0, 64'h0000_0000_4fff_fff0);
        out_op(2'h1, 2'h0, 64'h0000_0007_ffff_fff0, 64'h0000_0007_ffff_fff0);
        reg_op(1'b1, phbr_pkg::REG_CTRL, 64'h2);
        out_op(2'h0, 2'h0, 64'h0000_0008_0000_1000, 64'h0000_0008_0000_1000);
        reg_op(1'b1, phbr_pkg::REG_CTRL, 64'h3);
        // Back-to-back inbound traffic over every attribute combination
        for (int k = 0; k < 16; k++) in_op(k[3:0]);
        reg_op(1'b1, phbr_pkg::REG_CTRL, 64'h1);
        ama_on = 1'b1;
        for (int k = 0; k < 16; k++) in_op(k[3:0]);
        reg_op(1'b1, phbr_pkg::REG_CTRL, 64'h3);
        ama_on = 1'b0;
        idle(1);
        smmu_present <= 1'b1;
        idle(1);
        for (int k = 0; k < 4; k++) in_op(k[3:0]);
        idle(3);
        smmu_present <= 1'b0;
        for (int l = 0; l < 4; l++) intx(1'b1, l[1:0]);
        idle(2);
        chk(intx_irq === 4'hf, "legacy assert");
        intx(1'b0, 2'h2);
        idle(6);
        chk(intx_irq === 4'hb, "legacy level");
        intx(1'b0, 2'h0);
        idle(2);
        chk(intx_irq === 4'ha, "legacy release");
        reg_op(1'b0, phbr_pkg::REG_STATUS, 64'h0000_0000_0000_009a);
        idle(3);
        chk(sq.size() + pq.size() + rq.size() + aq.size() == 0, "missing result");
        stop_test();
    end
endmodule
